//--- core/psw_defs.svh
// register indexes, field positions and reset values of the phy select / wakeup block
`ifndef PSW_DEFS_SVH
`define PSW_DEFS_SVH
`define PSW_IDX_PHYADDR   8'h19
`define PSW_IDX_MONSTAT   8'h1C
`define PSW_IDX_MONCTL    8'h1D
`define PSW_IDX_SELSTAT   8'h21
`define PSW_IDX_SELCTL    8'h22
`define PSW_IDX_EECFG     8'h30
`define PSW_IDX_EEPHY     8'h31
`define PSW_IDX_USBCTL    8'h32
`define PSW_IDX_WAKESTAT  8'h33
`define PSW_IDX_RPT0      8'h34
`define PSW_IDX_RPT1      8'h35
`define PSW_SEL_CHOICE_BIT 0
`define PSW_SEL_AUTO_BIT   1
`define PSW_MON_MONITOR_BIT 0
`define PSW_MON_LINK_BIT    1
`define PSW_MON_MAGIC_BIT   2
`define PSW_EE_WAKE_BIT     16
`define PSW_USB_RWFEAT_BIT  0
`define PSW_RST_CHOICE  1'b1
`define PSW_RST_AUTO    1'b1
`define PSW_RST_LINKW   1'b0
`define PSW_RST_MAGICW  1'b0
`define PSW_RST_PINS    5'h10
`define PSW_PIN_EMB   0
`define PSW_PIN_PRI   1
`define PSW_PIN_SEC   2
`define PSW_PIN_IRQ   3
`define PSW_PIN_EXTW  4
`define PSW_RPT_HEAD  8'hA1
`define PSW_ST_PRI    0
`define PSW_ST_SEC    1
`define PSW_ST_LENERR 2
`define PSW_ST_IRQ    3
`endif

//--- core/psw_pkg.sv
// types of the phy select / wakeup block
package psw_pkg;
  typedef enum logic [2:0] {
    PSW_RUN  = 3'b001,
    PSW_SUSP = 3'b010,
    PSW_WAKE = 3'b100
  } psw_wake_state_t;

  typedef struct packed {
    logic [4:0]      sync1;
    logic [4:0]      sync2;
    logic [4:0]      sync3;
    logic            choice;
    logic            auto_sel;
    logic            monitor;
    logic            link_wen;
    logic            magic_wen;
    logic [16:0]     ee_cfg;
    logic [15:0]     ee_phy;
    logic            rw_feat;
    psw_wake_state_t st;
    logic [1:0]      saved_mode;
    logic            use_emb;
    logic            monitor_out;
    logic            suspended;
    logic            remote_wake;
    logic [2:0]      wake_cause;
    logic [7:0]      wake_count;
    logic            pready;
    logic            pslverr;
    logic [31:0]     prdata;
  } psw_top_state_t;

  typedef struct packed {
    logic        len_err;
    logic [63:0] report;
  } psw_rpt_state_t;
endpackage

//--- core/psw_report.sv
// interrupt endpoint report assembler
`timescale 1ns/1ps
`include "psw_defs.svh"
module psw_report (
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic        pri_link,
  input  wire logic        sec_link,
  input  wire logic        irq_level,
  input  wire logic        len_check,
  input  wire logic        len_bad,
  input  wire logic [15:0] reg_hi_val,
  input  wire logic [15:0] reg_lo_val,
  output logic      [63:0] report
);
  psw_pkg::psw_rpt_state_t q;
  psw_pkg::psw_rpt_state_t d;
  logic [7:0]              status;

  always_comb
  begin
    d = q;
    // each length check replaces the previous verdict
    if (len_check)
    begin
      d.len_err = len_bad;
    end
    status                     = 8'h00;
    status[`PSW_ST_PRI]        = pri_link;
    status[`PSW_ST_SEC]        = sec_link;
    status[`PSW_ST_LENERR]     = d.len_err;
    status[`PSW_ST_IRQ]        = irq_level;
    d.report = {`PSW_RPT_HEAD, 8'h00, status, 8'h00,
                reg_hi_val,
                reg_lo_val};
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      q <= '{len_err: 1'b0, report: {`PSW_RPT_HEAD, 56'h0}};
    end
    else
    begin
      q <= d;
    end
  end

  assign report = q.report;
endmodule // psw_report

//--- core/psw_top.sv
// phy selection, remote wakeup control and status report with apb registers
//
// Overview of operation
// - manual mode: phy_choice 1 picks embedded phy, 0 external mii phy; resets to 1
// - auto_choice 1 (reset value) selects by embedded link, ignoring phy_choice
// - auto_choice 0 selects using phy_choice only
// - controls written at 22h, read back at 21h; bit0 choice, bit1 auto
// - host resume always wakes a suspended device
// - after any wake the device resumes its pre-suspend operating mode
// - device wake only if wake_allow and host remote wakeup feature both set
// - permitted, magic_wake_en 1 and link_wake_en 0: magic packet wakes
// - permitted: link-up on either phy wakes if link_wake_en; ext_wake_n falling edge always
// - report is 8 bytes: A1, 00, status, 00, two phy register values
// - status bit0 shows primary phy link state
// - status bit1 shows secondary phy link state
// - status bit2 shows bulk out length parity error
// - status bit3 mirrors phy interrupt pin level
// - bytes five and six carry primary register named by word 0Fh high byte
// - bytes seven and eight carry primary register named by word 0Fh low byte
// - status bits 7 to 4 carry nothing
// - link_wake_en bit1, magic_wake_en bit2 of 1Dh, both reset to 0
// - primary and secondary phy addresses come from eeprom word 11h
`timescale 1ns/1ps
`include "psw_defs.svh"
module psw_top (
  input  wire logic        CLOCK,
  input  wire logic        SRST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [9:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic             PREADY,
  output logic      [31:0] PRDATA,
  output logic             PSLVERR,
  input  wire logic        USB_SUSPEND,
  input  wire logic        HOST_RESUME,
  input  wire logic        MAGIC_PKT,
  input  wire logic        LEN_CHECK,
  input  wire logic        LEN_PARITY_BAD,
  input  wire logic [15:0] PRI_REG_HI_VAL,
  input  wire logic [15:0] PRI_REG_LO_VAL,
  input  wire logic        LINK_EMB,
  input  wire logic        LINK_PRI,
  input  wire logic        LINK_SEC,
  input  wire logic        PHY_IRQ,
  input  wire logic        EXT_WAKE_N,
  output logic             USE_EMB_PHY,
  output logic             MONITOR_MODE,
  output logic             SUSPENDED,
  output logic             REMOTE_WAKE,
  output logic      [63:0] REPORT,
  output logic      [7:0]  PRI_REG_HI_IDX,
  output logic      [7:0]  PRI_REG_LO_IDX,
  output logic      [7:0]  PRI_PHY_ADDR,
  output logic      [7:0]  SEC_PHY_ADDR
);
  psw_pkg::psw_top_state_t q;
  psw_pkg::psw_top_state_t d;
  logic [7:0]              idx;
  logic                    acc_first;
  logic                    wr_now;
  logic                    mapped;
  logic [31:0]             rd_mux;
  logic                    link_pri_s;
  logic                    link_sec_s;
  logic                    link_emb_s;
  logic                    irq_s;
  logic                    pri_rise;
  logic                    sec_rise;
  logic                    extw_fall;
  logic                    dev_ok;
  logic                    ev_magic;
  logic                    ev_link;
  logic                    ev_ext;
  logic                    live_emb;
  logic [63:0]             report_w;

  // second synchroniser stage feeds all logic, third stage gives edges
  assign link_emb_s = q.sync2[`PSW_PIN_EMB];
  assign link_pri_s = q.sync2[`PSW_PIN_PRI];
  assign link_sec_s = q.sync2[`PSW_PIN_SEC];
  assign irq_s      = q.sync2[`PSW_PIN_IRQ];
  assign pri_rise   = q.sync2[`PSW_PIN_PRI] & ~q.sync3[`PSW_PIN_PRI];
  assign sec_rise   = q.sync2[`PSW_PIN_SEC] & ~q.sync3[`PSW_PIN_SEC];
  assign extw_fall  = ~q.sync2[`PSW_PIN_EXTW] & q.sync3[`PSW_PIN_EXTW];

  // wake sources
  assign dev_ok   = q.ee_cfg[`PSW_EE_WAKE_BIT] & q.rw_feat;
  assign ev_magic = dev_ok & q.magic_wen & ~q.link_wen & MAGIC_PKT;
  assign ev_link  = dev_ok & q.link_wen & (pri_rise | sec_rise);
  assign ev_ext   = dev_ok & extw_fall;

  // phy selection from live controls
  assign live_emb = q.auto_sel ? link_emb_s
                               : q.choice;

  // apb decode: one wait state, write lands on the completing edge
  assign idx       = PADDR[9:2];
  assign acc_first = PSEL & PENABLE & ~q.pready;
  assign wr_now    = PSEL & PENABLE & q.pready & PWRITE & ~q.pslverr;

  always_comb
  begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (idx)
      `PSW_IDX_PHYADDR:
      begin
        rd_mux = {16'h0000, q.ee_phy};
      end
      `PSW_IDX_MONSTAT:
      begin
        rd_mux = {29'h0000_0000, q.magic_wen, q.link_wen, q.monitor};
      end
      `PSW_IDX_SELSTAT:
      begin
        rd_mux = {30'h0000_0000, q.auto_sel, q.choice};
      end
      `PSW_IDX_EECFG:
      begin
        rd_mux = {15'h0000, q.ee_cfg};
      end
      `PSW_IDX_EEPHY:
      begin
        rd_mux = {16'h0000, q.ee_phy};
      end
      `PSW_IDX_USBCTL:
      begin
        rd_mux = {31'h0000_0000, q.rw_feat};
      end
      `PSW_IDX_WAKESTAT:
      begin
        rd_mux = {16'h0000, q.wake_count, 1'b0, q.wake_cause, q.use_emb,
                  q.st};
      end
      `PSW_IDX_RPT0:
      begin
        rd_mux = report_w[63:32];
      end
      `PSW_IDX_RPT1:
      begin
        rd_mux = report_w[31:0];
      end
      `PSW_IDX_MONCTL, `PSW_IDX_SELCTL:
      begin
        rd_mux = 32'h0000_0000;
      end
      default:
      begin
        mapped = 1'b0;
      end
    endcase
  end

  always_comb
  begin
    d = q;
    d.sync1 = {EXT_WAKE_N, PHY_IRQ, LINK_SEC, LINK_PRI, LINK_EMB};
    d.sync2 = q.sync1;
    d.sync3 = q.sync2;

    // bus answer
    d.pready  = acc_first;
    d.pslverr = acc_first & (~mapped | (PWRITE & (idx == `PSW_IDX_SELSTAT ||
                idx == `PSW_IDX_PHYADDR || idx == `PSW_IDX_MONSTAT ||
                idx == `PSW_IDX_WAKESTAT || idx == `PSW_IDX_RPT0 ||
                idx == `PSW_IDX_RPT1)));
    d.prdata  = (acc_first & ~PWRITE & mapped) ? rd_mux : 32'h0000_0000;

    // register writes
    if (wr_now)
    begin
      unique case (idx)
        `PSW_IDX_SELCTL:
        begin
          d.choice   = PWDATA[`PSW_SEL_CHOICE_BIT];
          d.auto_sel = PWDATA[`PSW_SEL_AUTO_BIT];
        end
        `PSW_IDX_MONCTL:
        begin
          d.monitor   = PWDATA[`PSW_MON_MONITOR_BIT];
          d.link_wen  = PWDATA[`PSW_MON_LINK_BIT];
          d.magic_wen = PWDATA[`PSW_MON_MAGIC_BIT];
        end
        `PSW_IDX_EECFG:
        begin
          d.ee_cfg = PWDATA[16:0];
        end
        `PSW_IDX_EEPHY:
        begin
          d.ee_phy = PWDATA[15:0];
        end
        `PSW_IDX_USBCTL:
        begin
          d.rw_feat = PWDATA[`PSW_USB_RWFEAT_BIT];
        end
        default:
        begin
        end
      endcase
    end

    // suspend / wake sequencing
    d.remote_wake = 1'b0;
    unique case (q.st)
      psw_pkg::PSW_RUN:
      begin
        d.use_emb     = live_emb;
        d.monitor_out = q.monitor;
        if (USB_SUSPEND)
        begin
          d.st         = psw_pkg::PSW_SUSP;
          d.suspended  = 1'b1;
          d.saved_mode = {q.monitor, live_emb};
        end
      end
      psw_pkg::PSW_SUSP:
      begin
        if (HOST_RESUME || !USB_SUSPEND)
        begin
          d.st         = psw_pkg::PSW_RUN;
          d.suspended  = 1'b0;
          d.wake_cause = 3'h0;
          d.use_emb     = q.saved_mode[0];
          d.monitor_out = q.saved_mode[1];
        end
        else if (ev_magic || ev_link || ev_ext)
        begin
          d.st          = psw_pkg::PSW_WAKE;
          d.remote_wake = 1'b1;
          d.wake_cause  = {ev_ext, ev_link, ev_magic};
          d.wake_count  = q.wake_count + 8'h01;
        end
      end
      psw_pkg::PSW_WAKE:
      begin
        // further events are ignored until the host answers the resume
        if (!USB_SUSPEND || HOST_RESUME)
        begin
          d.st          = psw_pkg::PSW_RUN;
          d.suspended   = 1'b0;
          d.use_emb     = q.saved_mode[0];
          d.monitor_out = q.saved_mode[1];
        end
      end
    endcase
  end

  always_ff @(posedge CLOCK)
  begin
    if (SRST)
    begin
      q <= '{sync1:     `PSW_RST_PINS,
             sync2:     `PSW_RST_PINS,
             sync3:     `PSW_RST_PINS,
             choice:    `PSW_RST_CHOICE,
             auto_sel:  `PSW_RST_AUTO,
             link_wen:  `PSW_RST_LINKW,
             magic_wen: `PSW_RST_MAGICW,
             st:        psw_pkg::PSW_RUN,
             use_emb:   `PSW_RST_CHOICE,
             default:   '0};
    end
    else
    begin
      q <= d;
    end
  end

  psw_report u_report (
    .clock      (CLOCK),
    .srst       (SRST),
    .pri_link   (link_pri_s),
    .sec_link   (link_sec_s),
    .irq_level  (irq_s),
    .len_check  (LEN_CHECK),
    .len_bad    (LEN_PARITY_BAD),
    .reg_hi_val (PRI_REG_HI_VAL),
    .reg_lo_val (PRI_REG_LO_VAL),
    .report     (report_w)
  );

  assign PREADY         = q.pready;
  assign PRDATA         = q.prdata;
  assign PSLVERR        = q.pslverr;
  assign USE_EMB_PHY    = q.use_emb;
  assign MONITOR_MODE   = q.monitor_out;
  assign SUSPENDED      = q.suspended;
  assign REMOTE_WAKE    = q.remote_wake;
  assign REPORT         = report_w;
  assign PRI_REG_HI_IDX = q.ee_cfg[15:8];
  assign PRI_REG_LO_IDX = q.ee_cfg[7:0];
  assign PRI_PHY_ADDR   = q.ee_phy[7:0];
  assign SEC_PHY_ADDR   = q.ee_phy[15:8];
endmodule // psw_top

//--- verification/psw_host_model.sv
// usb host side: suspend, resume and answer to device wake
`timescale 1ns/1ps
module psw_host_model (
  input  wire logic       clock,
  input  wire logic       srst,
  input  wire logic       remote_wake,
  input  wire logic       go_suspend,
  input  wire logic       send_resume,
  input  wire logic [3:0] wake_delay,
  output logic            usb_suspend,
  output logic            host_resume
);
  logic [4:0] cnt_q;
  always_ff @(posedge clock)
  begin
    host_resume <= 1'b0;
    if (srst)
    begin
      usb_suspend <= 1'b0;
      cnt_q <= 5'h00;
    end
    else if (send_resume && usb_suspend)
    begin
      host_resume <= 1'b1;
      usb_suspend <= 1'b0;
    end
    else if (go_suspend)
      usb_suspend <= 1'b1;
    else if (remote_wake)
      cnt_q <= {1'b0, wake_delay} + 5'h01;
    else if (cnt_q != 5'h00)
    begin
      cnt_q <= cnt_q - 5'h01;
      if (cnt_q == 5'h01)
        usb_suspend <= 1'b0;
    end
  end
endmodule // psw_host_model

//--- verification/psw_top_asserts.sv
// port assertions of the phy select / wakeup block
`timescale 1ns/1ps
module psw_top_asserts (
  input wire logic        CLOCK,
  input wire logic        SRST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        USB_SUSPEND,
  input wire logic        HOST_RESUME,
  input wire logic        LEN_CHECK,
  input wire logic        LEN_PARITY_BAD,
  input wire logic [15:0] PRI_REG_HI_VAL,
  input wire logic [15:0] PRI_REG_LO_VAL,
  input wire logic        USE_EMB_PHY,
  input wire logic        MONITOR_MODE,
  input wire logic        SUSPENDED,
  input wire logic        REMOTE_WAKE,
  input wire logic [63:0] REPORT
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (SRST);
  sequence s_setup;
    PSEL && !PENABLE;
  endsequence
  sequence s_answer;
    !PREADY ##1 PREADY;
  endsequence
  sequence s_len;
    LEN_CHECK ##1 !LEN_CHECK [*2];
  endsequence
  property p_ready;
    s_setup |=> s_answer;
  endproperty
  property p_err;
    PSLVERR |-> PREADY;
  endproperty
  property p_head;
    REPORT[63:56] == 8'hA1 && REPORT[55:48] == 8'h00 && REPORT[39:32] == 8'h00;
  endproperty
  property p_rsv;
    REPORT[47:44] == 4'h0;
  endproperty
  property p_hi;
    1'b1 |=> REPORT[31:16] == $past(PRI_REG_HI_VAL);
  endproperty
  property p_lo;
    1'b1 |=> REPORT[15:0] == $past(PRI_REG_LO_VAL);
  endproperty
  property p_len;
    s_len |-> REPORT[42] == $past(LEN_PARITY_BAD, 2);
  endproperty
  property p_host;
    SUSPENDED && HOST_RESUME |=> !SUSPENDED && !REMOTE_WAKE;
  endproperty
  property p_enter;
    USB_SUSPEND && !SUSPENDED |=> SUSPENDED;
  endproperty
  property p_hold;
    SUSPENDED |=> $stable(USE_EMB_PHY) && $stable(MONITOR_MODE);
  endproperty
  property p_once;
    REMOTE_WAKE |-> SUSPENDED ##1 !REMOTE_WAKE;
  endproperty
  a_ready: assert property (p_ready) else $error("apb answer late");
  a_err: assert property (p_err) else $error("error without ready");
  a_head: assert property (p_head) else $error("report fixed bytes");
  a_rsv: assert property (p_rsv) else $error("status upper bits");
  a_hi: assert property (p_hi) else $error("report high value");
  a_lo: assert property (p_lo) else $error("report low value");
  a_len: assert property (p_len) else $error("length error bit");
  a_host: assert property (p_host) else $error("host resume");
  a_enter: assert property (p_enter) else $error("suspend entry");
  a_hold: assert property (p_hold) else $error("mode not kept");
  a_once: assert property (p_once) else $error("wake pulse");
endmodule // psw_top_asserts

bind psw_top psw_top_asserts u_chk (.CLOCK, .SRST, .PSEL, .PENABLE, .PREADY, .PSLVERR,
  .USB_SUSPEND, .HOST_RESUME, .LEN_CHECK, .LEN_PARITY_BAD, .PRI_REG_HI_VAL,
  .PRI_REG_LO_VAL, .USE_EMB_PHY, .MONITOR_MODE, .SUSPENDED, .REMOTE_WAKE, .REPORT);

//--- verification/test_phy_select_wakeup_status.sv
// self-checking bench of the phy select / wakeup block
`timescale 1ns/1ps
module test_phy_select_wakeup_status;
  logic        clk, srst, psel, penable, pwrite, pready, pslverr;
  logic [9:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        magic_pkt, len_check, len_bad, link_emb, link_pri, link_sec;
  logic        phy_irq, ext_wake_n, use_emb, mon_mode, suspended, remote_wake;
  logic        usb_suspend, host_resume, go_suspend, send_resume;
  logic [3:0]  wake_delay;
  logic [15:0] hi_val, lo_val;
  logic [63:0] report;
  logic [7:0]  hi_idx, lo_idx, pri_addr, sec_addr;
  int          fail_count, check_count;
  int          cycles = 0;
  // {expect wake, event, magic_wake_en, link_wake_en, permission}
  localparam logic [5:0] wake_cases [8] = '{6'h04, 6'h25, 6'h2B, 6'h33,
                                            6'h39, 6'h07, 6'h09, 6'h18};

  psw_top dut (.CLOCK(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready),
    .PRDATA(prdata), .PSLVERR(pslverr), .USB_SUSPEND(usb_suspend),
    .HOST_RESUME(host_resume), .MAGIC_PKT(magic_pkt), .LEN_CHECK(len_check),
    .LEN_PARITY_BAD(len_bad), .PRI_REG_HI_VAL(hi_val), .PRI_REG_LO_VAL(lo_val),
    .LINK_EMB(link_emb), .LINK_PRI(link_pri), .LINK_SEC(link_sec), .PHY_IRQ(phy_irq),
    .EXT_WAKE_N(ext_wake_n), .USE_EMB_PHY(use_emb), .MONITOR_MODE(mon_mode),
    .SUSPENDED(suspended), .REMOTE_WAKE(remote_wake), .REPORT(report),
    .PRI_REG_HI_IDX(hi_idx), .PRI_REG_LO_IDX(lo_idx), .PRI_PHY_ADDR(pri_addr),
    .SEC_PHY_ADDR(sec_addr));
  psw_host_model host (.clock(clk), .srst(srst), .remote_wake(remote_wake),
    .go_suspend(go_suspend), .send_resume(send_resume), .wake_delay(wake_delay),
    .usb_suspend(usb_suspend), .host_resume(host_resume));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fail_count++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one apb transfer; d is write data or expected read data
  task automatic acc(input logic w, input logic [9:0] a, input logic [31:0] d,
                     input logic xe);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1);
    chk("pready", pready, 1'b1);
    chk("wait", n, 2);
    chk("pslverr", pslverr, xe);
    if (!w)
      chk("prdata", prdata, d);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic t_regs();
    acc(1'b0, 10'h084, 32'h3, 1'b0);
    acc(1'b0, 10'h070, 32'h0, 1'b0);
    acc(1'b0, 10'h3FC, 32'h0, 1'b1);
    acc(1'b1, 10'h084, 32'h0, 1'b1);
    acc(1'b0, 10'h088, 32'h0, 1'b0);
    acc(1'b1, 10'h074, 32'h7, 1'b0);
    acc(1'b0, 10'h070, 32'h7, 1'b0);
    chk("mon_mode", mon_mode, 1'b1);
    acc(1'b1, 10'h0C4, 32'h0000A5C3, 1'b0);
    repeat (2) @(posedge clk);
    chk("pri_addr", pri_addr, 8'hC3);
    chk("sec_addr", sec_addr, 8'hA5);
  endtask

  task automatic t_select();
    for (int i = 0; i < 8; i++)
    begin
      acc(1'b1, 10'h088, {30'h0, i[1:0]}, 1'b0);
      link_emb <= i[2];
      repeat (6) @(posedge clk);
      chk("use_emb", use_emb, i[1] ? i[2] : i[0]);
      acc(1'b0, 10'h084, {30'h0, i[1:0]}, 1'b0);
    end
  endtask

  task automatic t_report();
    logic [63:0] exp;
    for (int k = 0; k < 2; k++)
    begin
      exp = {8'hA1, 8'h00, 4'h0, k[0], !k[0], !k[0], k[0], 8'h00,
             16'hC0DE + k[15:0], 16'h5A5A - k[15:0]};
      link_pri <= k[0];
      link_sec <= !k[0];
      phy_irq <= k[0];
      hi_val <= exp[31:16];
      lo_val <= exp[15:0];
      len_check <= 1'b1;
      len_bad <= !k[0];
      @(posedge clk);
      len_check <= 1'b0;
      len_bad <= k[0];
      repeat (6) @(posedge clk);
      chk("report", report, exp);
      acc(1'b0, 10'h0D0, exp[63:32], 1'b0);
      acc(1'b0, 10'h0D4, exp[31:0], 1'b0);
    end
    acc(1'b1, 10'h0C0, 32'h00001F02, 1'b0);
    repeat (2) @(posedge clk);
    chk("hi_idx", hi_idx, 8'h1F);
    chk("lo_idx", lo_idx, 8'h02);
  endtask

  task automatic t_wake();
    logic [5:0] c;
    int n;
    link_pri <= 1'b0;
    link_sec <= 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      c = wake_cases[i];
      wake_delay <= i[3:0];
      link_emb <= 1'b0;
      // first and last cases grant only one half of the permission
      acc(1'b1, 10'h0C0, {15'h0, c[0] | (i == 7), 16'h0}, 1'b0);
      acc(1'b1, 10'h0C8, {31'h0, c[0] | (i == 0)}, 1'b0);
      acc(1'b1, 10'h074, {29'h0, c[2:1], 1'b0}, 1'b0);
      go_suspend <= 1'b1;
      @(posedge clk);
      go_suspend <= 1'b0;
      repeat (4) @(posedge clk);
      link_emb <= 1'b1;
      magic_pkt <= c[4:3] == 2'h0;
      link_pri <= c[4:3] == 2'h1;
      link_sec <= c[4:3] == 2'h2;
      ext_wake_n <= c[4:3] != 2'h3;
      n = 0;
      repeat (16)
      begin
        @(posedge clk);
        magic_pkt <= 1'b0;
        ext_wake_n <= 1'b1;
        if (remote_wake === 1'b1)
          n++;
      end
      chk("wake_count", n, c[5]);
      send_resume <= 1'b1;
      @(posedge clk);
      send_resume <= 1'b0;
      repeat (4) @(posedge clk);
      chk("suspended", suspended, 1'b0);
      link_pri <= 1'b0;
      link_sec <= 1'b0;
      repeat (6) @(posedge clk);
    end
  endtask

  initial
  begin
    {psel, penable, pwrite, magic_pkt, len_check, len_bad} = '0;
    {link_emb, link_pri, link_sec, phy_irq, go_suspend, send_resume} = '0;
    {paddr, pwdata, hi_val, lo_val, wake_delay} = '0;
    ext_wake_n = 1'b1;
    srst = 1'b1;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_select();
    t_report();
    t_wake();
    stop_test();
  end
endmodule // test_phy_select_wakeup_status
